// ==== qec_pkg.sv ====
package qec_pkg;

    // ----------------------------------------------------------------
    // Clocking and filter timing
    // ----------------------------------------------------------------
    localparam int unsigned QEC_CLK_HZ = 100_000_000;
    localparam int unsigned QEC_SAMPLE_HZ = 50_000_000;
    localparam int unsigned QEC_FILT_LONG = 15;
    localparam int unsigned QEC_FILT_SHORT = 3;
    localparam int unsigned QEC_FILT_CW = 4;
    localparam int unsigned QEC_DIV_W = 8;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned QEC_CNT_W = 32;
    localparam int unsigned QEC_ADDR_W = 8;
    localparam int unsigned QEC_DATA_W = 32;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] QEC_A_CTRL = 8'h00;
    localparam logic [7:0] QEC_A_COUNT = 8'h04;
    localparam logic [7:0] QEC_A_RAW = 8'h08;
    localparam logic [7:0] QEC_A_STAT = 8'h0C;
    localparam logic [7:0] QEC_A_MASK = 8'h10;
    localparam logic [7:0] QEC_A_PINS = 8'h14;

    localparam int unsigned QEC_CTRL_W = 7;
    localparam int unsigned QEC_C_MODE = 0;
    localparam int unsigned QEC_C_FILT = 1;
    localparam int unsigned QEC_C_IPOL = 2;
    localparam int unsigned QEC_C_MEN = 3;
    localparam int unsigned QEC_C_MPOL = 4;
    localparam int unsigned QEC_C_ARM = 5;
    localparam int unsigned QEC_C_CRST = 6;
    localparam logic [6:0] QEC_CTRL_RST = 7'h02;

    localparam int unsigned QEC_ST_W = 2;
    localparam int unsigned QEC_S_IDX = 0;
    localparam int unsigned QEC_S_ERR = 1;

    localparam int unsigned QEC_PIN_W = 4;
    localparam int unsigned QEC_P_A = 0;
    localparam int unsigned QEC_P_B = 1;
    localparam int unsigned QEC_P_IDX = 2;
    localparam int unsigned QEC_P_GATE = 3;

    typedef enum logic {
        QEC_MODE_QUAD = 1'b0,
        QEC_MODE_UPDN = 1'b1
    } qec_mode_t;

endpackage : qec_pkg

// ==== qec_filt.sv ====
module qec_filt #(
    parameter int unsigned CW = qec_pkg::QEC_FILT_CW
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic tick_i,
    input wire logic long_i,
    input wire logic pin_i,
    output logic lvl_o
);

    logic [2:0] sync_q, sync_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] lim;
    logic lvl_q, lvl_d;

    // The first stage only feeds the second; stages two and three must
    // agree before the filter sees a new level.
    always_comb begin
        sync_d = {sync_q[1:0], pin_i};
        lim = long_i ? CW'(qec_pkg::QEC_FILT_LONG)
                     : CW'(qec_pkg::QEC_FILT_SHORT);
        cnt_d = cnt_q;
        lvl_d = lvl_q;
        if (sync_q[2] != sync_q[1] || sync_q[2] == lvl_q) begin
            cnt_d = '0;
        end else if (tick_i) begin
            if (cnt_q >= lim - 1'b1) begin
                lvl_d = sync_q[2];
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_q <= '0;
            cnt_q <= '0;
            lvl_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
        end
    end

    assign lvl_o = lvl_q;

endmodule : qec_filt

// ==== qec_dec.sv ====
module qec_dec (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic a_i,
    input wire logic b_i,
    input wire logic updn_i,
    output logic inc_o,
    output logic dec_o,
    output logic err_o
);

    logic [1:0] prev_q, prev_d;
    logic inc_q, inc_d, dec_q, dec_d, err_q, err_d;

    always_comb begin
        prev_d = {a_i, b_i};
        inc_d = 1'b0;
        dec_d = 1'b0;
        err_d = 1'b0;
        if (updn_i) begin
            if (a_i && !prev_q[1]) begin
                inc_d = !b_i;
                dec_d = b_i;
            end
        end else if (prev_d != prev_q) begin
            if (prev_d == ~prev_q) begin
                err_d = 1'b1;
            end else begin
                inc_d = a_i ^ prev_q[0];
                dec_d = !(a_i ^ prev_q[0]);
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_q <= '0;
            inc_q <= 1'b0;
            dec_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            inc_q <= inc_d;
            dec_q <= dec_d;
            err_q <= err_d;
        end
    end

    assign inc_o = inc_q;
    assign dec_o = dec_q;
    assign err_o = err_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_quad_jump;
        @(posedge clk_i) disable iff (!resetn_i)
        !updn_i && ({a_i, b_i} == ~prev_q)
            |=> err_o && !inc_o && !dec_o;
    endproperty
    a_quad_jump: assert property (p_quad_jump)
        else $error("Double jump was counted.");

    property p_updn_rise;
        @(posedge clk_i) disable iff (!resetn_i)
        updn_i && a_i && !prev_q[1] |=> (inc_o == !$past(b_i)) && !err_o;
    endproperty
    a_updn_rise: assert property (p_updn_rise)
        else $error("Up/down count missed a rising edge.");

endmodule : qec_dec

// ==== qec_top.sv ====
// Operation
// - Three encoder inputs, four with gate option.
// - Signed 32-bit count since reset or marker.
// - Separate signed 32-bit raw tally, cleared only by resetn_i.
// - Armed marker event clears the count.
// - Marker clear drops the arm bit.
// - Count held zero while count reset set.
// - Count reset leaves velocity untouched.
// - Mode bit selects quadrature or up/down.
// - Quadrature gives four counts per line.
// - Up/down counts A rises, B gives direction.
// - Long filter needs 15 stable sample clocks.
// - Short filter needs 3 stable sample clocks.
// - Sample clock is 33 or 50 MHz.
// - Polarity bit picks marker edge; needs arm.
// - Gate use bit qualifies marker by gate.
// - Gate polarity bit: set means active low.
//
// The plain strobed port and the register offsets were chosen for this implementation.
module qec_top #(
    parameter int unsigned CLK_HZ = qec_pkg::QEC_CLK_HZ,
    parameter int unsigned SAMPLE_HZ = qec_pkg::QEC_SAMPLE_HZ,
    parameter bit GATE_EN = 1'b1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic enc_idx_i,
    input wire logic enc_gate_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [31:0] count_o,
    output logic [31:0] raw_o,
    output logic irq_o
);

    localparam int unsigned DW = qec_pkg::QEC_DATA_W;
    localparam int unsigned CNW = qec_pkg::QEC_CNT_W;
    localparam int unsigned PW = qec_pkg::QEC_PIN_W;
    localparam int unsigned SW = qec_pkg::QEC_ST_W;
    localparam int unsigned CTW = qec_pkg::QEC_CTRL_W;
    localparam int unsigned DVW = qec_pkg::QEC_DIV_W;
    localparam int unsigned DIV_RAW = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned DIV = (DIV_RAW < 1) ? 1 : DIV_RAW;

    // ----------------------------------------------------------------
    // Sample tick
    // ----------------------------------------------------------------
    // The filters count sample periods, not system clocks, so the
    // stability window keeps its length on either board rate.
    logic [DVW-1:0] div_q, div_d;
    logic tick;

    always_comb begin
        tick = (div_q == DVW'(DIV - 1));
        div_d = tick ? '0 : div_q + 1'b1;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // ----------------------------------------------------------------
    // Input filters
    // ----------------------------------------------------------------
    logic [CTW-1:0] ctrl_q, ctrl_d;
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_f;

    // Without the gate option the gate pin is tied off inside.
    assign pin_raw = {GATE_EN ? enc_gate_i : 1'b0,
                      enc_idx_i, enc_b_i, enc_a_i};

    genvar gi;
    generate
        for (gi = 0; gi < PW; gi++) begin : g_filt
            qec_filt #(
                .CW(qec_pkg::QEC_FILT_CW)
            ) u_filt (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .tick_i(tick),
                .long_i(ctrl_q[qec_pkg::QEC_C_FILT]),
                .pin_i(pin_raw[gi]),
                .lvl_o(pin_f[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Edge decoding
    // ----------------------------------------------------------------
    qec_pkg::qec_mode_t mode;
    logic cnt_inc, cnt_dec, cnt_err;

    assign mode = qec_pkg::qec_mode_t'(ctrl_q[qec_pkg::QEC_C_MODE]);

    qec_dec u_dec (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .a_i(pin_f[qec_pkg::QEC_P_A]),
        .b_i(pin_f[qec_pkg::QEC_P_B]),
        .updn_i(mode == qec_pkg::QEC_MODE_UPDN),
        .inc_o(cnt_inc),
        .dec_o(cnt_dec),
        .err_o(cnt_err)
    );

    // ----------------------------------------------------------------
    // Marker qualification
    // ----------------------------------------------------------------
    logic idx_prev_q, idx_prev_d;
    logic idx_now, idx_edge, gate_act, gate_ok, idx_evt;
    logic arm, crst;

    assign arm = ctrl_q[qec_pkg::QEC_C_ARM];
    assign crst = ctrl_q[qec_pkg::QEC_C_CRST];

    always_comb begin
        idx_now = pin_f[qec_pkg::QEC_P_IDX];
        idx_prev_d = idx_now;
        idx_edge = ctrl_q[qec_pkg::QEC_C_IPOL]
                 ? (idx_now && !idx_prev_q)
                 : (!idx_now && idx_prev_q);
        gate_act = ctrl_q[qec_pkg::QEC_C_MPOL]
                 ? !pin_f[qec_pkg::QEC_P_GATE]
                 : pin_f[qec_pkg::QEC_P_GATE];
        gate_ok = !ctrl_q[qec_pkg::QEC_C_MEN] || gate_act;
        idx_evt = idx_edge && gate_ok && arm;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idx_prev_q <= 1'b0;
        end else begin
            idx_prev_q <= idx_prev_d;
        end
    end

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    logic signed [CNW-1:0] count_q, count_d;
    logic signed [CNW-1:0] raw_q, raw_d;
    logic signed [CNW-1:0] delta;

    always_comb begin
        delta = '0;
        if (cnt_inc) begin
            delta = CNW'(1);
        end else if (cnt_dec) begin
            delta = -CNW'(1);
        end
        raw_d = raw_q + delta;
        if (crst) begin
            count_d = '0;
        end else if (idx_evt) begin
            count_d = '0;
        end else begin
            count_d = count_q + delta;
        end
    end

    // Velocity is estimated by the host from these counts; nothing
    // here scales or rate-limits it, so holding the count does not
    // touch it.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q <= '0;
            raw_q <= '0;
        end else begin
            count_q <= count_d;
            raw_q <= raw_d;
        end
    end

    assign count_o = count_q;
    assign raw_o = raw_q;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // One exact compare per register, so unmapped addresses never
    // alias onto live registers.
    function automatic logic bus_hit(input logic [7:0] adr,
                                     input logic [7:0] reg_a);
        return adr == reg_a;
    endfunction : bus_hit

    // ----------------------------------------------------------------
    // Registers and interrupt
    // ----------------------------------------------------------------
    logic [SW-1:0] stat_q, stat_d, mask_q, mask_d, stat_set;
    logic [DW-1:0] rdata_q, rdata_d;
    logic wr_ctrl, rd_stat;

    always_comb begin
        wr_ctrl = wr_i && bus_hit(addr_i, qec_pkg::QEC_A_CTRL);
        rd_stat = rd_i && bus_hit(addr_i, qec_pkg::QEC_A_STAT);
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = wdata_i[CTW-1:0];
        end
        // The marker taking the arm wins over a write in the same
        // cycle, so software always learns that it was consumed.
        if (idx_evt) begin
            ctrl_d[qec_pkg::QEC_C_ARM] = 1'b0;
        end
        mask_d = mask_q;
        if (wr_i && bus_hit(addr_i, qec_pkg::QEC_A_MASK)) begin
            mask_d = wdata_i[SW-1:0];
        end
        stat_set = '0;
        stat_set[qec_pkg::QEC_S_IDX] = idx_evt;
        stat_set[qec_pkg::QEC_S_ERR] = cnt_err;
        stat_d = (rd_stat ? '0 : stat_q) | stat_set;
        rdata_d = '0;
        if (rd_i) begin
            case (addr_i)
                qec_pkg::QEC_A_CTRL: rdata_d = DW'(ctrl_q);
                qec_pkg::QEC_A_COUNT: rdata_d = DW'(count_q);
                qec_pkg::QEC_A_RAW: rdata_d = DW'(raw_q);
                qec_pkg::QEC_A_STAT: rdata_d = DW'(stat_q);
                qec_pkg::QEC_A_MASK: rdata_d = DW'(mask_q);
                qec_pkg::QEC_A_PINS: rdata_d = DW'(pin_f);
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= qec_pkg::QEC_CTRL_RST;
            mask_q <= '0;
            stat_q <= '0;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = |(stat_q & mask_q);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_idx_clear;
        idx_evt && !crst |=> count_q == '0;
    endproperty
    a_idx_clear: assert property (p_idx_clear)
        else $error("Armed marker did not clear the count.");

    property p_arm_drop;
        idx_evt |=> !arm;
    endproperty
    a_arm_drop: assert property (p_arm_drop)
        else $error("Arm bit survived a marker event.");

    property p_crst_hold;
        crst [*2] |-> count_q == '0;
    endproperty
    a_crst_hold: assert property (p_crst_hold)
        else $error("Count moved while count reset held.");

    property p_raw_inc;
        cnt_inc |=> raw_q == $past(raw_q) + CNW'(1);
    endproperty
    a_raw_inc: assert property (p_raw_inc)
        else $error("Raw tally missed an increment.");

    property p_no_arm;
        !arm && !crst && !cnt_inc && !cnt_dec |=> count_q == $past(count_q);
    endproperty
    a_no_arm: assert property (p_no_arm)
        else $error("Marker acted while not armed.");

    property p_gate;
        ctrl_q[qec_pkg::QEC_C_MEN] && !gate_act && !crst && !cnt_inc
            && !cnt_dec |=> count_q == $past(count_q);
    endproperty
    a_gate: assert property (p_gate)
        else $error("Marker passed a closed gate.");

    property p_cnt_dec;
        cnt_dec && !crst && !idx_evt
            |=> count_q == $past(count_q) - CNW'(1);
    endproperty
    a_cnt_dec: assert property (p_cnt_dec)
        else $error("Count missed a decrement.");

    property p_stat_idx;
        idx_evt |=> stat_q[qec_pkg::QEC_S_IDX] [*1] ##1 1'b1;
    endproperty
    a_stat_idx: assert property (p_stat_idx)
        else $error("Marker event not flagged.");

    property p_cnt_inc;
        cnt_inc && !crst && !idx_evt
            |=> count_q == $past(count_q) + CNW'(1);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc)
        else $error("Count missed an increment.");

    property p_raw_hold;
        !cnt_inc && !cnt_dec |=> raw_q == $past(raw_q);
    endproperty
    a_raw_hold: assert property (p_raw_hold)
        else $error("Raw tally moved without a count.");

    property p_arm_keep;
        arm && !idx_evt && !wr_ctrl |=> arm;
    endproperty
    a_arm_keep: assert property (p_arm_keep)
        else $error("Arm bit dropped without a marker.");

    property p_stat_keep;
        stat_q[qec_pkg::QEC_S_IDX] && !rd_stat
            |=> stat_q[qec_pkg::QEC_S_IDX];
    endproperty
    a_stat_keep: assert property (p_stat_keep)
        else $error("Marker flag lost before it was read.");

    c_idx: cover property (idx_evt && gate_ok);
    c_crst: cover property (crst && cnt_inc);
    c_updn: cover property (cnt_dec && mode == qec_pkg::QEC_MODE_UPDN);
    c_err: cover property (cnt_err);
    c_irq: cover property (irq_o ##1 rd_stat);

endmodule : qec_top

// ==== qec_enc_model.sv ====
module qec_enc_model (
    input wire logic clk_i,
    output logic a_o,
    output logic b_o,
    output logic idx_o,
    output logic gate_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Encoder line state
    // ----------------------------------------------------------------
    // A forward walk through this order means A leads B.
    logic [1:0] gray [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int ph = 0;
    // Hold time per change; the bench shortens it for the short filter.
    int hold_cyc = 45;

    initial begin
        a_o = 1'h0;
        b_o = 1'h0;
        idx_o = 1'h0;
        gate_o = 1'h0;
    end

    // ----------------------------------------------------------------
    // Line drivers
    // ----------------------------------------------------------------
    task automatic wait_hold();
        repeat (hold_cyc) @(posedge clk_i);
    endtask : wait_hold

    // A step of two is a jump of both lines, only when the bench asks.
    task automatic step(input int dir);
        @(posedge clk_i);
        ph = (ph + dir) & 3;
        {a_o, b_o} <= gray[ph];
        wait_hold();
    endtask : step

    // Direction on B is set up a full hold before A rises.
    task automatic updn(input int dir);
        @(posedge clk_i);
        a_o <= 1'h0;
        b_o <= (dir < 0);
        wait_hold();
        a_o <= 1'h1;
        wait_hold();
        a_o <= 1'h0;
        wait_hold();
    endtask : updn

    // Marker on select 0, gating input on select 1.
    task automatic pin(input int sel, input logic v);
        @(posedge clk_i);
        if (sel == 0) begin
            idx_o <= v;
        end else begin
            gate_o <= v;
        end
        wait_hold();
    endtask : pin

    // Noise pulse on A of n clocks, shorter than any real edge.
    task automatic glitch(input int n);
        @(posedge clk_i);
        a_o <= ~a_o;
        repeat (n) @(posedge clk_i);
        a_o <= ~a_o;
        wait_hold();
    endtask : glitch
endmodule : qec_enc_model

// ==== qec_top_test.sv ====
module qec_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic a, b, idx, gate, irq_o;
    logic [31:0] rdata_o, count_o, raw_o, d;
    int n_mismatch = 0;
    int checks_done = 0;
    int cnt = 0;
    int raw = 0;
    bit crst = 0;
    logic qual;
    logic [4:0] mk;
    // Marker cases as {arm, gate level, gate polarity, gate use, edge}.
    logic [4:0] mk_tab [6] = '{5'h01, 5'h11, 5'h10, 5'h13, 5'h17, 5'h1A};

    qec_enc_model u_qec_enc_model (.clk_i(clk_i), .a_o(a), .b_o(b),
        .idx_o(idx), .gate_o(gate));

    qec_top #(.GATE_EN(1'h1)) u_qec_top (.clk_i(clk_i), .resetn_i(resetn_i),
        .enc_a_i(a), .enc_b_i(b), .enc_idx_i(idx), .enc_gate_i(gate),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .count_o(count_o), .raw_o(raw_o), .irq_o(irq_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // The host reports the encoder stopped once raw has sat still for
    // this many clocks; the design keeps no speed of its own.
    localparam int VEL_TMO = 50;
    int idle_cyc = 0;
    logic [31:0] raw_seen = 32'h0;

    always @(posedge clk_i) begin
        raw_seen <= raw_o;
        idle_cyc <= (raw_o !== raw_seen) ? 0 : idle_cyc + 1;
    end

    // ----------------------------------------------------------------
    // Compare, bus and model tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic bus_wr(input logic [7:0] a_v, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a_v;
        wdata_i <= v;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a_v, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a_v;
        rd_i <= 1'h1;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1;
        v = rdata_o;
    endtask : bus_rd

    // The model clears its count at once while count reset is written.
    task automatic wctl(input logic [6:0] c);
        bus_wr(qec_pkg::QEC_A_CTRL, {25'h0, c});
        crst = c[qec_pkg::QEC_C_CRST];
        if (crst) cnt = 0;
    endtask : wctl

    task automatic mv(input int dir, input int n);
        repeat (n) begin
            u_qec_enc_model.step(dir);
            raw += dir;
            if (!crst) cnt += dir;
        end
    endtask : mv

    task automatic check_all();
        #1;
        chk_word("count", 32'(cnt), count_o);
        chk_word("raw", 32'(raw), raw_o);
        bus_rd(qec_pkg::QEC_A_COUNT, d);
        chk_word("count reg", 32'(cnt), d);
        bus_rd(qec_pkg::QEC_A_PINS, d);
        chk_word("pins", {28'h0, gate, idx, b, a}, d);
    endtask : check_all

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(30));
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'h1;
        check_all();
        bus_rd(qec_pkg::QEC_A_CTRL, d);
        chk_word("ctrl", 32'h2, d);
        bus_wr(8'h20, $urandom());
        bus_rd(8'h20, d);
        chk_word("unmapped", 32'h0, d);
        bus_rd(qec_pkg::QEC_A_CTRL, d);
        chk_word("ctrl", 32'h2, d);
        repeat (10) begin
            mv(($urandom() % 2) ? 1 : -1, 1 + $urandom() % 3);
            check_all();
        end
        // Walking back past zero shows the count is signed.
        mv(-1, (cnt < 0) ? 2 : cnt + 2);
        check_all();
        chk_bit("stopped", 1'h0, idle_cyc >= VEL_TMO);
        u_qec_enc_model.glitch(26);
        check_all();
        chk_bit("stopped", 1'h1, idle_cyc >= VEL_TMO);
        wctl(7'h00);
        u_qec_enc_model.hold_cyc = 16;
        u_qec_enc_model.glitch(3);
        check_all();
        mv(1, 4);
        check_all();
        u_qec_enc_model.step(2);
        check_all();
        chk_bit("irq masked", 1'h0, irq_o);
        bus_wr(qec_pkg::QEC_A_MASK, 32'h3);
        #1;
        chk_bit("irq", 1'h1, irq_o);
        bus_rd(qec_pkg::QEC_A_STAT, d);
        chk_word("stat", 32'h2, d);
        chk_bit("irq cleared", 1'h0, irq_o);
        bus_rd(qec_pkg::QEC_A_STAT, d);
        chk_word("stat", 32'h0, d);
        wctl(7'h40);
        mv(1, 2);
        check_all();
        wctl(7'h00);
        mv(-1, 1);
        check_all();
        foreach (mk_tab[i]) begin
            mk = mk_tab[i];
            qual = mk[4] && (!mk[1] || (mk[3] == !mk[2]));
            u_qec_enc_model.pin(1, mk[3]);
            wctl({1'h0, mk[4], mk[2], mk[1], mk[0], 2'h0});
            mv(1, 1);
            u_qec_enc_model.pin(0, 1'h1);
            u_qec_enc_model.pin(0, 1'h0);
            if (qual) cnt = 0;
            #1;
            chk_bit("irq", qual, irq_o);
            check_all();
            bus_rd(qec_pkg::QEC_A_CTRL, d);
            chk_bit("arm", mk[4] && !qual, d[qec_pkg::QEC_C_ARM]);
            bus_rd(qec_pkg::QEC_A_STAT, d);
            chk_word("stat", {31'h0, qual}, d);
        end
        wctl(7'h01);
        for (int i = 0; i < 6; i++) begin
            // Both directions come first, then random ones.
            mk[0] = (i < 2) ? 1'(i) : 1'($urandom() % 2);
            u_qec_enc_model.updn(mk[0] ? -1 : 1);
            raw += mk[0] ? -1 : 1;
            cnt += mk[0] ? -1 : 1;
            check_all();
        end
        tally_and_finish();
    end

    // Whole run needs well under ten thousand clocks.
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : qec_top_test
